/* pkg/mrc_pkg.sv */
// Memory map, register layout and reset sequencing constants for the remap and reset control block
package mrc_pkg;
   // Memory regions, byte addresses
   localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
   localparam logic [31:0] SRAM_BYTES = 32'h0000_1800;
   localparam int SRAM_WORDS = 1536;
   localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
   localparam logic [31:0] FLASH_BYTES = 32'h0001_8000;
   localparam int FLASH_WORDS = 24576;
   localparam logic [31:0] MIRROR_BASE = 32'h0000_0000;
   localparam logic [31:0] MIRROR_BYTES = 32'h0001_7800;
   localparam logic [31:0] FLASH_ERASED = 32'hffff_ffff;

   // Register byte addresses
   localparam logic [31:0] REMAP_ADDR = 32'hffff_0220;
   localparam logic [31:0] CAUSE_ADDR = 32'hffff_0230;
   localparam logic [31:0] CLEAR_ADDR = 32'hffff_0234;
   localparam logic [31:0] SRAM_STAT_ADDR = 32'hffff_0238;

   // Field positions
   localparam int REMAP_BIT = 0;
   localparam int CAUSE_W = 4;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_WDT = 1;
   localparam int CAUSE_SW = 2;
   localparam int CAUSE_EXT = 3;
   localparam int LVF_EN_BIT = 2;
   localparam int LVF_STAT_BIT = 6;
   localparam int SRAM_VALID_BIT = 0;

   // Reset values
   localparam logic [3:0] CAUSE_AFTER_POR = 4'h1;
   localparam logic REMAP_RESET = 1'b0;

   // Byte enables accepted for flash programming
   localparam logic [3:0] BE_LOW_HALF = 4'h3;
   localparam logic [3:0] BE_HIGH_HALF = 4'hc;

   // Avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Reset sequencing counts in clock cycles
   localparam logic [7:0] HOLD_CYCLES = 8'h04;
   localparam logic [7:0] KERNEL_CYCLES = 8'h10;

   // Reset sequencer states
   typedef enum logic [1:0] {
      SEQ_HOLD = 2'b00,
      SEQ_KERNEL = 2'b01,
      SEQ_RUN = 2'b10
   } mrc_seq_t;
endpackage : mrc_pkg

/* rtl/mrc_top.sv */
// Memory decode, bottom remap, reset cause recording and reset sequencing
//
// What this block does
// - Multi-byte data stored little endian.
// - SRAM of 1536 words at 0x40000.
// - SRAM byte, halfword, word reads and writes.
// - Flash at 0x80000, mirrored at bottom.
// - After reset, bottom maps to flash.
// - Remap bit set puts SRAM at bottom.
// - Every reset clears the remap bit.
// - Reset runs hidden kernel, then vector zero.
// - Cause bits: POR, watchdog, software, pin.
// - Cause bits 7 to 4 read zero.
// - Writing cause bit 2 starts software reset.
// - Clear register clears cause bits written one.
// - Clear write keeping bit 2 resets again.
// - Resets restart all but cause; POR only watchdog.
// - SRAM invalid after reset following serial download.
// - POR keeps SRAM only with flag enabled, set.
// - Flash reads any size, writes halfwords only.
// - Erased flash reads all ones.
// - Word fetch from flash in two cycles.
// - Unmapped access answers with data abort.
//
// The Avalon-MM register port was chosen for this implementation.
module mrc_top #(
   parameter int SRAM_WORDS = mrc_pkg::SRAM_WORDS,
   parameter int FLASH_WORDS = mrc_pkg::FLASH_WORDS
) (
   // Clock and power-on reset
   input wire logic clock,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   // Abort toward the core
   output logic data_abort,
   // Reset sources
   input wire logic watchdog_timeout,
   input wire logic ext_reset_pin_n,
   // Download and low voltage flag inputs
   input wire logic lin_download_active,
   input wire logic [7:0] high_voltage_config_zero,
   input wire logic [7:0] high_voltage_status,
   // Reset effects toward the system
   output logic system_reset,
   output logic kernel_mode,
   output logic watchdog_timer_reset,
   output logic sram_valid,
   output logic remap_sram
);
   // Notes for users of this block
   // Bus timing: a request is taken at the first edge outside the hold phase,
   // the answer stands for exactly one cycle after that edge, and the next
   // request may follow at the edge after the answer. Every access therefore
   // costs two cycles at best, longer while the sequencer holds the system.
   // Requests presented during the hold phase are not lost; they stall until
   // the kernel phase starts and are then answered in the usual way.
   // A write that triggers a software reset is still answered, so the master
   // never hangs on its own reset request.
   // The bottom mirror is decoded from the remap bit as it stands in the cycle
   // of the request. The bit only changes at a taking edge or on a reset event,
   // so no access ever sees half of one map and half of the other.
   // With remap set, only the first SRAM-sized slice of the mirror is backed;
   // the rest of the mirror then answers with a decode error.
   // Flash contents are modelled as words of two halfwords; a halfword write
   // stores its value directly, with no erase sequence and no program time.
   // Erase, program timing and page limits belong to the flash controller.
   // Cause bits accumulate across internal resets; only power-on or the clear
   // register brings them back. An event in the same cycle as a clear wins.
   // The external pin is a level: holding it low keeps the system in hold.
   // The watchdog timer is only reset on the way out of power-on, since the
   // power-on flag drops once the first hold phase has run to its end.
   // Storage is never touched by any reset; the validity flag tells software
   // whether the SRAM contents may be trusted after the last reset.
   localparam int SRAM_AW = $clog2(SRAM_WORDS);
   localparam int FLASH_AW = $clog2(FLASH_WORDS);

   // Sequencer and control state
   mrc_pkg::mrc_seq_t state;
   mrc_pkg::mrc_seq_t next_state;
   logic [7:0] count;
   logic [7:0] next_count;
   logic [mrc_pkg::CAUSE_W-1:0] cause;
   logic [mrc_pkg::CAUSE_W-1:0] next_cause;
   logic por_flag;
   logic lin_seen;
   logic ext_sync1;
   logic ext_sync2;

   // Storage
   logic [31:0] sram_mem [SRAM_WORDS];
   // Nonvolatile flash array starts erased
   logic [31:0] flash_mem [FLASH_WORDS] = '{default: mrc_pkg::FLASH_ERASED};

   // Decode results
   logic [31:0] sram_off;
   logic [31:0] flash_off;
   logic hit_sram;
   logic hit_flash;
   logic hit_remap;
   logic hit_cause;
   logic hit_clear;
   logic hit_stat;
   logic [SRAM_AW-1:0] sram_idx;
   logic [FLASH_AW-1:0] flash_idx;
   logic take;
   logic wr;
   logic flash_wr_ok;
   logic [31:0] next_rdata;
   logic [1:0] next_resp;
   logic sw_trig;
   logic ext_trig;
   logic reset_event;
   logic hold_done;
   logic kernel_done;

   // Address decode of the three memory regions and the registers
   always_comb begin
      sram_off = avs_address - mrc_pkg::SRAM_BASE;
      flash_off = avs_address - mrc_pkg::FLASH_BASE;
      hit_sram = 1'b0;
      hit_flash = 1'b0;
      sram_idx = '0;
      flash_idx = '0;
      if (avs_address >= mrc_pkg::SRAM_BASE && sram_off < mrc_pkg::SRAM_BYTES) begin
         hit_sram = 1'b1;
         sram_idx = sram_off[SRAM_AW+1:2];
      end else if (avs_address >= mrc_pkg::FLASH_BASE && flash_off < mrc_pkg::FLASH_BYTES) begin
         hit_flash = 1'b1;
         flash_idx = flash_off[FLASH_AW+1:2];
      end else if (avs_address - mrc_pkg::MIRROR_BASE < mrc_pkg::MIRROR_BYTES) begin
         // Bottom mirror follows the remap bit as it stands now
         if (remap_sram) begin
            hit_sram = avs_address < mrc_pkg::SRAM_BYTES;
            sram_idx = avs_address[SRAM_AW+1:2];
         end else begin
            hit_flash = 1'b1;
            flash_idx = avs_address[FLASH_AW+1:2];
         end
      end
      hit_remap = avs_address == mrc_pkg::REMAP_ADDR;
      hit_cause = avs_address == mrc_pkg::CAUSE_ADDR;
      hit_clear = avs_address == mrc_pkg::CLEAR_ADDR;
      hit_stat = avs_address == mrc_pkg::SRAM_STAT_ADDR;
   end

   // Request taken when pending, not yet answered and not held in reset
   assign take = (avs_read || avs_write) && avs_waitrequest && state != mrc_pkg::SEQ_HOLD;
   assign wr = take && avs_write;
   // Flash accepts only one aligned halfword per write
   assign flash_wr_ok = avs_byteenable == mrc_pkg::BE_LOW_HALF
      || avs_byteenable == mrc_pkg::BE_HIGH_HALF;

   // Read data and response for the taken request
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_resp = mrc_pkg::RESP_OKAY;
      if (hit_sram) begin
         if (avs_read) begin
            next_rdata = sram_mem[sram_idx];
         end
      end else if (hit_flash) begin
         if (avs_read) begin
            // Both halfwords of a word delivered together
            next_rdata = flash_mem[flash_idx];
         end else if (!flash_wr_ok) begin
            next_resp = mrc_pkg::RESP_SLVERR;
         end
      end else if (hit_remap) begin
         next_rdata[mrc_pkg::REMAP_BIT] = remap_sram;
      end else if (hit_cause) begin
         next_rdata[mrc_pkg::CAUSE_W-1:0] = cause;
      end else if (hit_clear) begin
         next_rdata = 32'h0000_0000;
      end else if (hit_stat) begin
         next_rdata[mrc_pkg::SRAM_VALID_BIT] = sram_valid;
      end else begin
         next_resp = mrc_pkg::RESP_DECERR;
      end
   end

   // One wait state, then answer for one cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         avs_response <= mrc_pkg::RESP_OKAY;
         data_abort <= 1'b0;
      end else if (take) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= next_rdata;
         avs_response <= next_resp;
         data_abort <= next_resp != mrc_pkg::RESP_OKAY;
      end else begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         avs_response <= mrc_pkg::RESP_OKAY;
         data_abort <= 1'b0;
      end
   end

   // SRAM byte lane writes, not cleared by reset
   always_ff @(posedge clock) begin
      if (wr && hit_sram) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
               sram_mem[sram_idx][8*b+:8] <= avs_writedata[8*b+:8];
            end
         end
      end
   end

   // Flash halfword programming
   always_ff @(posedge clock) begin
      if (wr && hit_flash && flash_wr_ok) begin
         if (avs_byteenable == mrc_pkg::BE_LOW_HALF) begin
            flash_mem[flash_idx][15:0] <= avs_writedata[15:0];
         end else begin
            flash_mem[flash_idx][31:16] <= avs_writedata[31:16];
         end
      end
   end

   // External reset pin synchroniser
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_sync1 <= 1'b1;
         ext_sync2 <= 1'b1;
      end else begin
         ext_sync1 <= ext_reset_pin_n;
         ext_sync2 <= ext_sync1;
      end
   end

   // Reset triggers other than power-on
   assign ext_trig = !ext_sync2;
   assign sw_trig = (wr && hit_cause && avs_byteenable[0] && avs_writedata[mrc_pkg::CAUSE_SW])
      || (wr && hit_clear && avs_byteenable[0] && cause[mrc_pkg::CAUSE_SW]
      && !avs_writedata[mrc_pkg::CAUSE_SW]);
   assign reset_event = sw_trig || ext_trig || watchdog_timeout;

   // Cause bits: clear by one-writes, new events win over the clear
   always_comb begin
      next_cause = cause;
      if (wr && hit_clear && avs_byteenable[0]) begin
         next_cause = cause & ~avs_writedata[mrc_pkg::CAUSE_W-1:0];
      end
      if (watchdog_timeout) begin
         next_cause[mrc_pkg::CAUSE_WDT] = 1'b1;
      end
      if (sw_trig) begin
         next_cause[mrc_pkg::CAUSE_SW] = 1'b1;
      end
      if (ext_trig) begin
         next_cause[mrc_pkg::CAUSE_EXT] = 1'b1;
      end
   end

   // Cause register survives all but power-on
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cause <= mrc_pkg::CAUSE_AFTER_POR;
      end else begin
         cause <= next_cause;
      end
   end

   // Remap bit, cleared by every reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         remap_sram <= mrc_pkg::REMAP_RESET;
      end else if (reset_event) begin
         remap_sram <= mrc_pkg::REMAP_RESET;
      end else if (wr && hit_remap && avs_byteenable[0]) begin
         // Decode uses the new value from the next request on
         remap_sram <= avs_writedata[mrc_pkg::REMAP_BIT];
      end
   end

   // Sequencer: hold system reset, run kernel, then user code
   assign hold_done = count == mrc_pkg::HOLD_CYCLES - 8'h01;
   assign kernel_done = count == mrc_pkg::KERNEL_CYCLES - 8'h01;

   always_comb begin
      next_state = state;
      next_count = count + 8'h01;
      if (reset_event) begin
         next_state = mrc_pkg::SEQ_HOLD;
         next_count = 8'h00;
      end else begin
         case (state)
            mrc_pkg::SEQ_HOLD: begin
               if (hold_done) begin
                  next_state = mrc_pkg::SEQ_KERNEL;
                  next_count = 8'h00;
               end
            end
            mrc_pkg::SEQ_KERNEL: begin
               if (kernel_done) begin
                  next_state = mrc_pkg::SEQ_RUN;
                  next_count = 8'h00;
               end
            end
            mrc_pkg::SEQ_RUN: begin
               next_count = 8'h00;
            end
            default: begin
               next_state = mrc_pkg::SEQ_HOLD;
               next_count = 8'h00;
            end
         endcase
      end
   end

   // Sequencer state and registered reset outputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= mrc_pkg::SEQ_HOLD;
         count <= 8'h00;
         system_reset <= 1'b1;
         kernel_mode <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         system_reset <= next_state == mrc_pkg::SEQ_HOLD;
         kernel_mode <= next_state == mrc_pkg::SEQ_KERNEL;
      end
   end

   // Watchdog timer reset only for power-on
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         por_flag <= 1'b1;
         watchdog_timer_reset <= 1'b1;
      end else begin
         if (state == mrc_pkg::SEQ_HOLD && hold_done && !reset_event) begin
            por_flag <= 1'b0;
         end
         watchdog_timer_reset <= por_flag && next_state == mrc_pkg::SEQ_HOLD;
      end
   end

   // Serial download seen since the last reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lin_seen <= 1'b0;
      end else if (lin_download_active) begin
         lin_seen <= 1'b1;
      end else if (state == mrc_pkg::SEQ_HOLD && hold_done) begin
         lin_seen <= 1'b0;
      end
   end

   // SRAM validity judged once per reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sram_valid <= 1'b0;
      end else if (reset_event && !por_flag) begin
         sram_valid <= !lin_seen;
      end else if (state == mrc_pkg::SEQ_HOLD && hold_done && por_flag) begin
         // Power-on: only a flagged, intact supply keeps contents
         sram_valid <= high_voltage_config_zero[mrc_pkg::LVF_EN_BIT]
            && high_voltage_status[mrc_pkg::LVF_STAT_BIT] && !lin_seen;
      end
   end
endmodule : mrc_top

/* tb/mrc_top_asserts.sv */
// Assertions on the ports of the remap and reset control block
module mrc_top_asserts (
   // Clock and power-on reset
   input wire logic clock,
   input wire logic reset_n,
   // Register bus
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0] avs_response,
   input wire logic avs_waitrequest,
   input wire logic data_abort,
   // Reset sources and effects
   input wire logic watchdog_timeout,
   input wire logic system_reset,
   input wire logic kernel_mode,
   input wire logic watchdog_timer_reset,
   input wire logic remap_sram
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // Abort only with an error answer
   property p_abort;
      data_abort |-> !avs_waitrequest && avs_response[1];
   endproperty
   a_abort: assert property (p_abort) else $error("abort without error answer");

   // Flash at the bottom while held in reset
   property p_hold_flash;
      system_reset |-> !remap_sram;
   endproperty
   a_hold_flash: assert property (p_hold_flash) else $error("remap set during hold");

   // Hold phase lasts at least four cycles
   property p_hold_len;
      $rose(system_reset) |-> system_reset [*4];
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold too short");

   // Kernel phase of sixteen cycles after hold
   property p_kernel;
      $fell(system_reset) |-> kernel_mode [*8] ##8 kernel_mode ##1 !kernel_mode;
   endproperty
   a_kernel: assert property (p_kernel) else $error("kernel phase length wrong");

   // Watchdog reset leaves the watchdog timer alone
   property p_wdt;
      watchdog_timeout && !system_reset |-> ##[1:2] (system_reset && !watchdog_timer_reset);
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog reset effect wrong");

   // Upper cause bits read zero
   property p_cause_hi;
      !avs_waitrequest && avs_read && avs_address == mrc_pkg::CAUSE_ADDR |-> avs_readdata[31:4] == 28'h0;
   endproperty
   a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits not zero");

   // Writing cause bit 2 starts a software reset
   property p_sw;
      !avs_waitrequest && avs_write && avs_address == mrc_pkg::CAUSE_ADDR && avs_byteenable[0]
         && avs_writedata[2] |-> ##[0:2] system_reset;
   endproperty
   a_sw: assert property (p_sw) else $error("no software reset");

   // Remap only rises on a remap register write
   property p_remap_set;
      $rose(remap_sram) |-> !avs_waitrequest && avs_write && avs_address == mrc_pkg::REMAP_ADDR;
   endproperty
   a_remap_set: assert property (p_remap_set) else $error("remap set without write");
endmodule : mrc_top_asserts

bind mrc_top mrc_top_asserts u_chk (.clock, .reset_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest, .data_abort,
   .watchdog_timeout, .system_reset, .kernel_mode, .watchdog_timer_reset, .remap_sram);

/* tb/mrc_core_model.sv */
// Processor core model issuing single bus transfers
module mrc_core_model (
   // Clock
   input wire logic clock,
   // Bus toward the block
   output logic [31:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0] avs_response,
   input wire logic avs_waitrequest,
   input wire logic data_abort
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      avs_address = 32'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end

   // One transfer held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
         output logic [31:0] q, output logic [1:0] resp, output logic ab);
      @(posedge clock);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      resp = avs_response;
      ab = data_abort;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a; // Released lines lose the old value
      avs_writedata <= ~d;
   endtask : xfer
endmodule : mrc_core_model

/* tb/mrc_top_tb.sv */
// Self-checking bench for the remap and reset control block
module mrc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic watchdog_timeout = 1'b0;
   logic ext_reset_pin_n = 1'b1;
   logic lin_download_active = 1'b0;
   logic [7:0] high_voltage_config_zero = 8'h04;
   logic [7:0] high_voltage_status = 8'h40;
   logic [31:0] avs_address, avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [1:0] avs_response, resp;
   logic avs_read, avs_write, avs_waitrequest, data_abort, ab;
   logic system_reset, kernel_mode, watchdog_timer_reset, sram_valid, remap_sram;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;

   // Clock of 100 ns period
   always #50 clock = ~clock;

   mrc_top dut (.clock, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_response, .avs_waitrequest, .data_abort, .watchdog_timeout, .ext_reset_pin_n,
      .lin_download_active, .high_voltage_config_zero, .high_voltage_status, .system_reset, .kernel_mode,
      .watchdog_timer_reset, .sram_valid, .remap_sram);

   mrc_core_model core (.clock, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_response, .avs_waitrequest, .data_abort);

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      core.xfer(1'b1, a, d, be, q, resp, ab);
   endtask : wr

   task rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
      core.xfer(1'b0, a, 32'h0, 4'hf, q, resp, ab);
      chk(name, q, exp);
   endtask : rdc

   // Waits until a reset has run through hold and kernel
   task wait_run;
      wait (system_reset === 1'b1);
      wait (kernel_mode === 1'b1);
      wait (kernel_mode === 1'b0);
      @(posedge clock);
   endtask : wait_run

   task t_por;
      @(posedge clock);
      chk("wdt timer reset", 32'(watchdog_timer_reset), 32'h1);
      wait_run;
      chk("remap", 32'(remap_sram), 32'h0);
      rdc("cause", mrc_pkg::CAUSE_ADDR, 32'h1);
      rdc("remap reg", mrc_pkg::REMAP_ADDR, 32'h0);
      rdc("bottom", 32'h0, 32'hffffffff);
      chk("sram valid", 32'(sram_valid), 32'h1);
      $display("t_por done");
   endtask : t_por

   task t_sram;
      wr(32'h40000, 32'h11223344, 4'hf);
      wr(32'h40000, 32'h0000aa00, 4'h2);
      rdc("sram lanes", 32'h40000, 32'h1122aa44);
      wr(32'h417fc, 32'h5a5a0001, 4'hf);
      rdc("sram top", 32'h417fc, 32'h5a5a0001);
      rdc("past sram", 32'h41800, 32'h0);
      chk("past sram err", 32'({ab, resp}), 32'h7);
      rdc("unmapped", 32'hffff0300, 32'h0);
      chk("unmapped err", 32'({ab, resp}), 32'h7);
      $display("t_sram done");
   endtask : t_sram

   task t_flash;
      wr(32'h80004, 32'h0000beef, 4'h3);
      rdc("flash low half", 32'h80004, 32'hffffbeef);
      wr(32'h80008, 32'h77660000, 4'hc);
      rdc("flash high half", 32'h80008, 32'h7766ffff);
      wr(32'h80004, 32'h12345678, 4'h1);
      chk("flash byte write", 32'({ab, resp}), 32'h6);
      rdc("flash kept", 32'h80004, 32'hffffbeef);
      rdc("mirror", 32'h4, 32'hffffbeef);
      $display("t_flash done");
   endtask : t_flash

   task t_remap;
      wr(mrc_pkg::REMAP_ADDR, 32'h1, 4'h1);
      rdc("bottom sram", 32'h0, 32'h1122aa44);
      wr(32'h4, 32'hcafe0004, 4'hf);
      rdc("sram via bottom", 32'h40004, 32'hcafe0004);
      wr(mrc_pkg::REMAP_ADDR, 32'h0, 4'h1);
      rdc("bottom flash", 32'h4, 32'hffffbeef);
      $display("t_remap done");
   endtask : t_remap

   task t_resets;
      int bit_of[3] = '{1, 3, 2};
      for (int k = 0; k < 3; k++) begin
         wr(mrc_pkg::CLEAR_ADDR, 32'hf, 4'h1);
         wr(mrc_pkg::REMAP_ADDR, 32'h1, 4'h1);
         if (k == 0) begin
            watchdog_timeout <= 1'b1;
            @(posedge clock);
            watchdog_timeout <= 1'b0;
         end else if (k == 1) begin
            ext_reset_pin_n <= 1'b0;
            repeat (4) @(posedge clock);
            ext_reset_pin_n <= 1'b1;
         end else begin
            wr(mrc_pkg::CAUSE_ADDR, 32'h4, 4'h1);
         end
         wait_run;
         chk("remap after reset", 32'(remap_sram), 32'h0);
         rdc("cause", mrc_pkg::CAUSE_ADDR, 32'h1 << bit_of[k]);
         rdc("bottom after reset", 32'h0, 32'hffffffff);
         chk("sram valid", 32'(sram_valid), 32'h1);
      end
      $display("t_resets done");
   endtask : t_resets

   task t_clear;
      wr(mrc_pkg::CLEAR_ADDR, 32'hf, 4'h1);
      rdc("cause cleared", mrc_pkg::CAUSE_ADDR, 32'h0);
      rdc("clear reg", mrc_pkg::CLEAR_ADDR, 32'h0);
      wr(mrc_pkg::CAUSE_ADDR, 32'h4, 4'h1);
      wait_run;
      rdc("sw cause", mrc_pkg::CAUSE_ADDR, 32'h4);
      // A clear that keeps bit 2 must reset again, else the run times out
      wr(mrc_pkg::CLEAR_ADDR, 32'h1, 4'h1);
      wait_run;
      rdc("sw still set", mrc_pkg::CAUSE_ADDR, 32'h4);
      wr(mrc_pkg::CLEAR_ADDR, 32'h4, 4'h1);
      repeat (3) @(posedge clock);
      chk("no reset", 32'(system_reset), 32'h0);
      rdc("cause none", mrc_pkg::CAUSE_ADDR, 32'h0);
      $display("t_clear done");
   endtask : t_clear

   task t_download;
      lin_download_active <= 1'b1;
      @(posedge clock);
      watchdog_timeout <= 1'b1;
      @(posedge clock);
      watchdog_timeout <= 1'b0;
      wait_run;
      chk("sram after download", 32'(sram_valid), 32'h0);
      rdc("sram status", mrc_pkg::SRAM_STAT_ADDR, 32'h0);
      chk("kernel done", 32'(kernel_mode), 32'h0);
      lin_download_active <= 1'b0;
      $display("t_download done");
   endtask : t_download

   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   // Cycle ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up;
      end
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      t_por;
      t_sram;
      t_flash;
      t_remap;
      t_resets;
      t_clear;
      t_download;
      wrap_up;
   end
endmodule : mrc_top_tb
